/* sfcr_top.sv */
/*
 * Serial-loaded configuration bank of a fractional-N synthesizer.
 * Assumes the three serial pins are asynchronous to CLK_IN and that the
 * serial clock is slow enough to be sampled after two flip-flops.
 */
// Functional notes
// - code 000 updates integer/fraction word
// - 12-bit integer divide value output
// - 12-bit fractional numerator to interpolator
// - test output select from DB30..DB27
// - code 001 loads 12-bit phase word
// - phase step is full turn over modulus
// - code 010 updates modulus/reference word
// - noise mode DB30:29, lowest spur dithers
// - lowest noise disables dither, quiet pump
// - slip reduction enable bit drives output
// - pump current from DB27..DB24
// - halving bit inserts toggle stage
// - DB20 selects reference doubler
// - 5-bit reference counter, ratio 1..32
// - 12-bit modulus as fraction denominator
// - divider mode DB20:19, count DB18..7
// - code 011 loads function word bits
// - buffered settings apply at next int write
// - 32 bits MSB first, latch on strobe
// - divider mode off, fast-lock, resync
`timescale 1ns/10ps
`include "sfcr_regs.svh"

module sfcr_top (
    // Clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        SRST_IN,
    // Serial load pins
    input  wire logic        SER_DATA_IN,
    input  wire logic        SER_CLK_IN,
    input  wire logic        LOAD_STROBE_IN,
    // Feedback divider settings
    output logic      [11:0] INT_VALUE_OUT,
    output logic      [11:0] FRACTIONAL_NUMERATOR_OUT,
    output logic      [11:0] FRACTIONAL_MODULUS_OUT,
    output logic      [11:0] PHASE_WORD_OUT,
    output logic       [3:0] TEST_OUTPUT_SELECT_OUT,
    output logic             INT_WRITE_PULSE_OUT,
    // Noise and pump settings
    output logic       [1:0] NOISE_MODE_OUT,
    output logic             DITHER_ENABLE_OUT,
    output logic             PUMP_LOW_NOISE_OUT,
    output logic             SLIP_REDUCTION_ENABLE_OUT,
    output logic       [3:0] PUMP_CURRENT_FIELD_OUT,
    output logic             PRESCALER_89_OUT,
    // Reference path settings
    output logic             REFERENCE_HALVING_OUT,
    output logic             REF_DOUBLER_OUT,
    output logic             REF_BOTH_EDGES_OUT,
    output logic       [5:0] REF_DIVIDE_RATIO_OUT,
    // Function settings
    output logic             COUNTER_RESET_OUT,
    output logic             PUMP_HIGH_IMPEDANCE_OUT,
    output logic             POWER_DOWN_OUT,
    output logic             DETECTOR_POLARITY_OUT,
    output logic             LOCK_PRECISION_SELECT_OUT,
    output logic             MODULATOR_RESET_PULSE_OUT,
    // Clock divider settings
    output sfcr_pkg::sfcr_cdmode_t CLK_DIV_MODE_OUT,
    output logic      [11:0] CLK_DIV_COUNT_OUT
);

    // Synchronisers for the three pins
    logic [1:0]  dat_s_r;
    logic [1:0]  sck_s_r;
    logic [1:0]  ld_s_r;
    logic        sck_d_r;
    logic        ld_d_r;
    logic [31:0] shift_r;

    // Active and pending (double-buffered) copies
    logic [31:0] w0_r;
    logic [31:0] w1_pend_r;
    logic [31:0] w2_pend_r;
    logic [31:0] w1_r;
    logic [31:0] w2_r;
    logic [31:0] w3_r;
    logic [31:0] w4_r;
    logic        int_pulse_r;
    logic        sdrst_pulse_r;

    wire sck_rise = sck_s_r[1] & ~sck_d_r;
    wire ld_rise  = ld_s_r[1] & ~ld_d_r;
    wire [2:0] sel = shift_r[2:0];
    wire wr0 = ld_rise && sel == `SFCR_SEL_INTFRAC;
    wire wr1 = ld_rise && sel == `SFCR_SEL_PHASE;
    wire wr2 = ld_rise && sel == `SFCR_SEL_MODREF;
    wire wr3 = ld_rise && sel == `SFCR_SEL_FUNC;
    wire wr4 = ld_rise && sel == `SFCR_SEL_CLKDIV;
    // Codes 101..111 match none of the strobes above

    always_ff @(posedge CLK_IN) begin
        dat_s_r <= {dat_s_r[0], SER_DATA_IN};
        sck_s_r <= {sck_s_r[0], SER_CLK_IN};
        ld_s_r  <= {ld_s_r[0], LOAD_STROBE_IN};
        sck_d_r <= sck_s_r[1];
        ld_d_r  <= ld_s_r[1];
    end

    // Shift on serial clock rising edge, MSB first
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            shift_r <= 32'h0;
        end else if (sck_rise) begin
            shift_r <= {shift_r[30:0], dat_s_r[1]};
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            w0_r          <= 32'h0;
            w1_pend_r     <= 32'h0;
            w2_pend_r     <= 32'h0;
            w1_r          <= 32'h0;
            w2_r          <= 32'h0;
            w3_r          <= 32'h0;
            w4_r          <= 32'h0;
            int_pulse_r   <= 1'b0;
            sdrst_pulse_r <= 1'b0;
        end else begin
            int_pulse_r   <= wr0;
            sdrst_pulse_r <= wr0 && !w3_r[`SFCR_SDRST_BIT];
            if (wr1) begin
                w1_pend_r <= shift_r;
            end
            if (wr2) begin
                w2_pend_r <= shift_r;
            end
            if (wr3) begin
                w3_r <= shift_r;
            end
            if (wr4) begin
                w4_r <= shift_r;
            end
            // Buffered settings move to active on integer write
            if (wr0) begin
                w0_r <= shift_r;
                w1_r <= w1_pend_r;
                w2_r <= w2_pend_r;
            end
        end
    end

    // Unbuffered fields of the modulus word act at once
    wire [1:0] noise_mode = w2_pend_r[`SFCR_NOISE_LSB +: 2];

    // Field extraction
    assign INT_VALUE_OUT = w0_r[`SFCR_INT_LSB +: 12];
    assign FRACTIONAL_NUMERATOR_OUT = w0_r[`SFCR_FRACTIONAL_NUMERATOR_LSB +: 12];
    assign TEST_OUTPUT_SELECT_OUT = w0_r[`SFCR_TSEL_LSB +: 4];
    assign INT_WRITE_PULSE_OUT = int_pulse_r;
    // Phase step is one modulus unit of a full turn
    assign PHASE_WORD_OUT = w1_r[`SFCR_PHASE_LSB +: 12];
    assign FRACTIONAL_MODULUS_OUT = w2_r[`SFCR_MOD_LSB +: 12];
    assign NOISE_MODE_OUT = noise_mode;
    assign DITHER_ENABLE_OUT = noise_mode == `SFCR_NOISE_LOWSPUR;
    // Lowest noise: no dither and quiet pump region
    assign PUMP_LOW_NOISE_OUT = noise_mode == `SFCR_NOISE_LOWNOISE;
    assign SLIP_REDUCTION_ENABLE_OUT = w2_pend_r[`SFCR_CSR_BIT];
    assign PUMP_CURRENT_FIELD_OUT = w2_r[`SFCR_CPI_LSB +: 4];
    assign PRESCALER_89_OUT = w2_pend_r[`SFCR_PRESC_BIT];
    assign REFERENCE_HALVING_OUT = w2_r[`SFCR_HALF_BIT];
    assign REF_DOUBLER_OUT = w2_r[`SFCR_DBL_BIT];
    assign REF_BOTH_EDGES_OUT = w2_r[`SFCR_DBL_BIT];
    // Field value 0 means divide by 32
    assign REF_DIVIDE_RATIO_OUT = (w2_r[`SFCR_RCNT_LSB +: 5] == 5'h0)
        ? 6'h20 : {1'b0, w2_r[`SFCR_RCNT_LSB +: 5]};
    assign COUNTER_RESET_OUT = w3_r[`SFCR_CNTRST_BIT];
    assign PUMP_HIGH_IMPEDANCE_OUT = w3_r[`SFCR_HIZ_BIT]
        | w3_r[`SFCR_PDN_BIT];
    assign POWER_DOWN_OUT = w3_r[`SFCR_PDN_BIT];
    assign DETECTOR_POLARITY_OUT = w3_r[`SFCR_POL_BIT];
    assign LOCK_PRECISION_SELECT_OUT = w3_r[`SFCR_LDP_BIT];
    assign MODULATOR_RESET_PULSE_OUT = sdrst_pulse_r;
    // Mode 00 none, 01 fast-lock, 10 resync
    assign CLK_DIV_MODE_OUT =
        sfcr_pkg::sfcr_cdmode_t'(w4_r[`SFCR_CDMODE_LSB +: 2]);
    assign CLK_DIV_COUNT_OUT = w4_r[`SFCR_CDIV_LSB +: 12];

endmodule

/* sfcr_regs.svh */
/*
 * Bit positions, target codes and field layouts of the synthesizer
 * configuration words. Assumes words are 32 bits, DB31 first.
 */
`ifndef SFCR_REGS_SVH
`define SFCR_REGS_SVH

`define SFCR_WORD_W        32
`define SFCR_SEL_W         3
`define SFCR_SEL_INTFRAC   3'h0
`define SFCR_SEL_PHASE     3'h1
`define SFCR_SEL_MODREF    3'h2
`define SFCR_SEL_FUNC      3'h3
`define SFCR_SEL_CLKDIV    3'h4
// Integer/fraction word
`define SFCR_FRACTIONAL_NUMERATOR_LSB      3
`define SFCR_INT_LSB       15
`define SFCR_TSEL_LSB      27
// Phase word
`define SFCR_PHASE_LSB     3
// Modulus/reference word
`define SFCR_MOD_LSB       3
`define SFCR_RCNT_LSB      15
`define SFCR_DBL_BIT       20
`define SFCR_HALF_BIT      21
`define SFCR_PRESC_BIT     22
`define SFCR_CPI_LSB       24
`define SFCR_CSR_BIT       28
`define SFCR_NOISE_LSB     29
// Function word
`define SFCR_CNTRST_BIT    3
`define SFCR_HIZ_BIT       4
`define SFCR_PDN_BIT       5
`define SFCR_POL_BIT       6
`define SFCR_LDP_BIT       7
`define SFCR_SDRST_BIT     14
// Clock-divider word
`define SFCR_CDIV_LSB      7
`define SFCR_CDMODE_LSB    19
// Noise/spur mode codes
`define SFCR_NOISE_LOWNOISE 2'h0
`define SFCR_NOISE_LOWSPUR  2'h3

`endif

/* sfcr_pkg.sv */
/*
 * Types for the synthesizer configuration bank.
 * Assumes nothing beyond the constants header.
 */
package sfcr_pkg;
    typedef enum logic [1:0] {
        SFCR_CD_OFF      = 2'h0,
        SFCR_CD_FASTLOCK = 2'h1,
        SFCR_CD_RESYNC   = 2'h2,
        SFCR_CD_RSVD     = 2'h3
    } sfcr_cdmode_t;
endpackage

/* sfcr_top_chk.sv */
/* Output relations of the synthesizer configuration bank.
   Assumes it is bound to sfcr_top and sees only its ports. */
`timescale 1ns/10ps
module sfcr_top_chk (
    // Clock and reset
    input wire logic        CLK_IN,
    input wire logic        SRST_IN,
    // Watched settings
    input wire logic [1:0]  NOISE_MODE_OUT,
    input wire logic        DITHER_ENABLE_OUT,
    input wire logic        PUMP_LOW_NOISE_OUT,
    input wire logic        REF_DOUBLER_OUT,
    input wire logic        REF_BOTH_EDGES_OUT,
    input wire logic        POWER_DOWN_OUT,
    input wire logic        PUMP_HIGH_IMPEDANCE_OUT,
    input wire logic [5:0]  REF_DIVIDE_RATIO_OUT,
    input wire logic        INT_WRITE_PULSE_OUT,
    input wire logic        MODULATOR_RESET_PULSE_OUT,
    input wire logic [11:0] FRACTIONAL_MODULUS_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);
    sequence s_pulse_once;
        INT_WRITE_PULSE_OUT ##1 !INT_WRITE_PULSE_OUT;
    endsequence
    a_dither_low_spur: assert property (
        DITHER_ENABLE_OUT == (NOISE_MODE_OUT == 2'h3))
        else $error("dither mismatch");
    a_quiet_pump_mode: assert property (
        PUMP_LOW_NOISE_OUT == (NOISE_MODE_OUT == 2'h0))
        else $error("pump mode mismatch");
    a_both_edges_doubler: assert property (
        REF_BOTH_EDGES_OUT == REF_DOUBLER_OUT)
        else $error("edge select mismatch");
    a_hiz_on_pdn: assert property (
        POWER_DOWN_OUT |-> PUMP_HIGH_IMPEDANCE_OUT)
        else $error("pump active in power-down");
    a_ratio_in_range: assert property (
        REF_DIVIDE_RATIO_OUT inside {[6'h01:6'h20]})
        else $error("reference ratio out of range");
    a_int_pulse_once: assert property (
        $rose(INT_WRITE_PULSE_OUT) |-> s_pulse_once)
        else $error("write pulse too long");
    a_modrst_with_int: assert property (
        MODULATOR_RESET_PULSE_OUT |-> INT_WRITE_PULSE_OUT)
        else $error("modulator reset without word0 load");
    a_modulus_buffered: assert property (
        $changed(FRACTIONAL_MODULUS_OUT)
        |-> INT_WRITE_PULSE_OUT || $past(INT_WRITE_PULSE_OUT))
        else $error("modulus changed without word0 load");
endmodule
bind sfcr_top sfcr_top_chk u_chk (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN),
    .NOISE_MODE_OUT(NOISE_MODE_OUT), .DITHER_ENABLE_OUT(DITHER_ENABLE_OUT),
    .PUMP_LOW_NOISE_OUT(PUMP_LOW_NOISE_OUT),
    .REF_DOUBLER_OUT(REF_DOUBLER_OUT), .REF_BOTH_EDGES_OUT(REF_BOTH_EDGES_OUT),
    .POWER_DOWN_OUT(POWER_DOWN_OUT),
    .PUMP_HIGH_IMPEDANCE_OUT(PUMP_HIGH_IMPEDANCE_OUT),
    .REF_DIVIDE_RATIO_OUT(REF_DIVIDE_RATIO_OUT),
    .INT_WRITE_PULSE_OUT(INT_WRITE_PULSE_OUT),
    .MODULATOR_RESET_PULSE_OUT(MODULATOR_RESET_PULSE_OUT),
    .FRACTIONAL_MODULUS_OUT(FRACTIONAL_MODULUS_OUT));

/* sfcr_host.sv */
/* Host controller model: shifts one 32-bit word onto the serial pins.
   Assumes CLK_IN paces it; clock and strobe levels last four cycles, each data bit eight. */
`timescale 1ns/10ps
module sfcr_host (
    // Control
    input  wire logic        clk_in,
    input  wire logic        go_in,
    input  wire logic [31:0] word_in,
    // Serial pins
    output logic             sdat_out,
    output logic             sclk_out,
    output logic             le_out,
    output logic             busy_out
);
    initial {sdat_out, sclk_out, le_out, busy_out} = 4'h0;
    always @(posedge clk_in) begin
        if (go_in && !busy_out) begin
            busy_out <= 1'b1;
            for (int i = 31; i >= 0; i--) begin
                sdat_out <= word_in[i];
                repeat (4) @(posedge clk_in);
                sclk_out <= 1'b1;
                repeat (4) @(posedge clk_in);
                sclk_out <= 1'b0;
            end
            // Data line no longer holds the last bit
            sdat_out <= ~word_in[0];
            le_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            le_out <= 1'b0;
            repeat (4) @(posedge clk_in);
            busy_out <= 1'b0;
        end
    end
endmodule

/* sfcr_top_tb.sv */
/* Testbench: loads words through the host model and checks settings.
   Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/10ps
module sfcr_top_tb;
    logic CLK_IN = 1'b0, SRST_IN = 1'b1, go = 1'b0, busy;
    logic SER_DATA_IN, SER_CLK_IN, LOAD_STROBE_IN;
    logic [31:0] word = 32'h0;
    int bad_count = 0, comparisons = 0;
    logic [11:0] INT_VALUE_OUT, FRACTIONAL_NUMERATOR_OUT, PHASE_WORD_OUT,
        FRACTIONAL_MODULUS_OUT, CLK_DIV_COUNT_OUT;
    logic [3:0] TEST_OUTPUT_SELECT_OUT, PUMP_CURRENT_FIELD_OUT;
    logic [1:0] NOISE_MODE_OUT;
    logic [5:0] REF_DIVIDE_RATIO_OUT;
    sfcr_pkg::sfcr_cdmode_t CLK_DIV_MODE_OUT;
    logic INT_WRITE_PULSE_OUT, DITHER_ENABLE_OUT, PUMP_LOW_NOISE_OUT,
        SLIP_REDUCTION_ENABLE_OUT, PRESCALER_89_OUT, REFERENCE_HALVING_OUT,
        REF_DOUBLER_OUT, REF_BOTH_EDGES_OUT, COUNTER_RESET_OUT,
        PUMP_HIGH_IMPEDANCE_OUT, POWER_DOWN_OUT, DETECTOR_POLARITY_OUT,
        LOCK_PRECISION_SELECT_OUT, MODULATOR_RESET_PULSE_OUT;
    always #5 CLK_IN = ~CLK_IN;
    sfcr_host host (.clk_in(CLK_IN), .go_in(go), .word_in(word),
        .sdat_out(SER_DATA_IN), .sclk_out(SER_CLK_IN),
        .le_out(LOAD_STROBE_IN), .busy_out(busy));
    sfcr_top dut (.*);
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [47:0] e, g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Whole serial load; returns once the strobe has long fallen
    task automatic load(input logic [31:0] w);
        int n;
        @(posedge CLK_IN);
        word <= w;
        go <= 1'b1;
        repeat (2) @(posedge CLK_IN);
        go <= 1'b0;
        for (n = 0; n < 400 && busy === 1'b1; n++) @(posedge CLK_IN);
        if (n == 400) begin
            bad_count++;
            end_of_test();
        end
        #1;
    endtask
    initial begin
        repeat (5) @(posedge CLK_IN);
        SRST_IN <= 1'b0;
        #1;
        chk("rst", {INT_VALUE_OUT, REF_DIVIDE_RATIO_OUT}, 32'h20);
        load(32'h6570_0322);
        chk("mr1", {NOISE_MODE_OUT, DITHER_ENABLE_OUT, PUMP_LOW_NOISE_OUT,
            FRACTIONAL_MODULUS_OUT, PUMP_CURRENT_FIELD_OUT}, 32'he0000);
        load(32'h0000_0039);
        chk("ph", PHASE_WORD_OUT, 32'h0);
        load(32'h4825_8028);
        chk("w0", {INT_VALUE_OUT, FRACTIONAL_NUMERATOR_OUT,
            TEST_OUTPUT_SELECT_OUT}, {12'h4b, 12'h5, 4'h9});
        chk("buf", {FRACTIONAL_MODULUS_OUT, PHASE_WORD_OUT, PUMP_CURRENT_FIELD_OUT,
            REF_DIVIDE_RATIO_OUT, REF_DOUBLER_OUT, REF_BOTH_EDGES_OUT,
            REFERENCE_HALVING_OUT}, {12'h64, 12'h7, 4'h5, 6'h20, 3'h7});
        load(32'h0000_40fb);
        chk("fn1", {COUNTER_RESET_OUT, PUMP_HIGH_IMPEDANCE_OUT, POWER_DOWN_OUT,
            DETECTOR_POLARITY_OUT, LOCK_PRECISION_SELECT_OUT}, 32'h1f);
        load(32'h0000_0043);
        chk("fn2", {COUNTER_RESET_OUT, PUMP_HIGH_IMPEDANCE_OUT, POWER_DOWN_OUT,
            DETECTOR_POLARITY_OUT, LOCK_PRECISION_SELECT_OUT}, 32'h02);
        load(32'h1061_8322);
        chk("mr2", {NOISE_MODE_OUT, DITHER_ENABLE_OUT, PUMP_LOW_NOISE_OUT,
            SLIP_REDUCTION_ENABLE_OUT, PRESCALER_89_OUT,
            REF_DIVIDE_RATIO_OUT}, {2'h0, 4'h7, 6'h20});
        load(32'h4825_8028);
        chk("rcnt", {REF_DIVIDE_RATIO_OUT, REFERENCE_HALVING_OUT,
            REF_DOUBLER_OUT, PUMP_CURRENT_FIELD_OUT}, {6'h3, 2'h2, 4'h0});
        for (int m = 0; m < 3; m++) begin
            load({11'h0, m[1:0], 10'h200, m[1:0], 4'h0, 3'h4});
            chk("cd", {CLK_DIV_MODE_OUT, CLK_DIV_COUNT_OUT},
                {m[1:0], 10'h200, m[1:0]});
        end
        for (int c = 5; c < 8; c++) begin
            load({29'h1fff_ffff, c[2:0]});
            chk("ign", {INT_VALUE_OUT, CLK_DIV_MODE_OUT, FRACTIONAL_MODULUS_OUT},
                {12'h4b, 2'h2, 12'h64});
        end
        end_of_test();
    end
endmodule
